/* design/swp_sector_write_protection.sv */
// sector write protection block with avalon-mm register slave
module swp_sector_write_protection
	import swp_pkg::*;
#(
	parameter int SECTORS = 16,
	parameter int PROG_CYCLES = SWP_PROG_CYCLES,
	parameter int ERASE_CYCLES = SWP_ERASE_CYCLES
) (
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	// hardware reset pin
	input wire logic i_hw_reset_n,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// protection state
	output logic [SECTORS-1:0] o_sector_write_ok,
	output logic o_persistent_bit_lock
);
	localparam int SW = (SECTORS > 1) ? $clog2(SECTORS) : 1;

	function automatic logic [SECTORS-1:0] swp_onehot(input logic [SW-1:0] idx);
		logic [SECTORS-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction

	swp_state_type state_r;
	logic [15:0] timer_r;
	logic [3:0] op_r;
	logic [SW-1:0] op_sect_r;
	logic op_abort_r;
	logic [SECTORS-1:0] persistent_sector_bit_r;
	logic [SECTORS-1:0] volatile_sector_bit_r;
	logic [SECTORS-1:0] ok_r;
	logic lock_r;
	logic [15:0] guard_config_word_r;
	logic [63:0] password_r;
	logic [31:0] pw_lo_r;
	logic [31:0] pw_hi_r;
	logic [15:0] cfg_data_r;
	logic aso_r;
	logic err_prog_r;
	logic err_erase_r;
	logic err_lock_r;
	logic ppb_rd_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic hw_s1_r;
	logic hw_s2_r;
	logic hw_s3_r;
	logic hw_filt_r;

	// bus decode
	wire logic req = i_avs_read | i_avs_write;
	wire logic wr_take = i_avs_write & ~wait_r;
	wire logic idle = (state_r == SWP_ST_IDLE);
	wire logic cmd_go = wr_take & (i_avs_address == SWP_REG_CMD) & idle;
	wire logic [3:0] cmd_op = i_avs_writedata[SWP_CMD_OP_LSB +: 4];
	wire logic [7:0] cmd_sect_full = i_avs_writedata[SWP_CMD_SECT_LSB +: 8];
	wire logic [SW-1:0] cmd_sect = cmd_sect_full[SW-1:0];
	wire logic sect_ok = (32'(cmd_sect_full) < 32'(SECTORS));
	wire logic hw_rst = ~hw_filt_r;
	wire logic [1:0] mode = guard_config_word_r[SWP_CFG_MODE_LSB +: 2];
	wire logic mode_pw = (mode == SWP_MODE_PASSWORD);
	wire logic cfg_frozen = (mode != SWP_MODE_BOOT_TEMP);
	wire logic cfg_both = (cfg_data_r[SWP_CFG_MODE_LSB +: 2] == SWP_MODE_NONE);
	wire logic pw_match = ({pw_hi_r, pw_lo_r} == password_r);
	// command strobes
	wire logic go_prog = cmd_go & (cmd_op == SWP_OP_PPB_PROG) & sect_ok;
	wire logic go_erase = cmd_go & (cmd_op == SWP_OP_PPB_ERASE);
	wire logic go_cfg = cmd_go & (cmd_op == SWP_OP_CFG_PROG);
	wire logic go_pw = cmd_go & (cmd_op == SWP_OP_PW_PROG);
	wire logic go_busy = go_prog | go_erase | go_cfg | go_pw;
	wire logic go_lock_clr = cmd_go & (cmd_op == SWP_OP_LOCK_CLEAR);
	wire logic go_unlock = cmd_go & (cmd_op == SWP_OP_PW_UNLOCK);
	wire logic go_dyb_p = cmd_go & (cmd_op == SWP_OP_DYB_PROTECT) & sect_ok;
	wire logic go_dyb_u = cmd_go & (cmd_op == SWP_OP_DYB_UNPROTECT) & sect_ok;
	wire logic go_aso_in = cmd_go & (cmd_op == SWP_OP_ASO_ENTER);
	wire logic go_aso_out = cmd_go & ((cmd_op == SWP_OP_ASO_EXIT) | (cmd_op == SWP_OP_SW_RESET));
	wire logic go_ppb_rd = cmd_go & (cmd_op == SWP_OP_PPB_STATUS) & sect_ok & aso_r;
	wire logic go_st_clr = cmd_go & (cmd_op == SWP_OP_STATUS_CLEAR);
	wire logic start_abort = ((go_prog | go_erase) & ~lock_r) | (go_cfg & (cfg_frozen | cfg_both))
		| (go_pw & cfg_frozen);
	wire logic [15:0] start_time = go_erase ? 16'(ERASE_CYCLES) : 16'(PROG_CYCLES);
	// completion
	wire logic done = ~idle & (timer_r == 16'h0001);
	wire logic done_ok = done & ~op_abort_r;
	wire logic done_bad = done & op_abort_r;
	wire logic is_prog = (op_r == SWP_OP_PPB_PROG);
	wire logic is_erase = (op_r == SWP_OP_PPB_ERASE);
	wire logic is_cfg = (op_r == SWP_OP_CFG_PROG);
	wire logic is_pw = (op_r == SWP_OP_PW_PROG);
	// error flags, set wins over clear
	wire logic err_prog_nxt = (err_prog_r & ~go_st_clr) | (done_bad & (is_prog | is_cfg | is_pw));
	wire logic err_erase_nxt = (err_erase_r & ~go_st_clr) | (done_bad & is_erase);
	wire logic err_lock_nxt = (err_lock_r & ~go_st_clr) | (done_bad & (is_prog | is_erase | is_cfg));
	// read data selection
	wire logic [31:0] status_word = {22'h0, aso_r, lock_r, idle, 1'b0, err_erase_r, err_prog_r,
		2'h0, err_lock_r, ppb_rd_r};
	wire logic [31:0] rd_mux = (i_avs_address == SWP_REG_STATUS) ? status_word :
		(i_avs_address == SWP_REG_CFG) ? {16'h0, guard_config_word_r} :
		(i_avs_address == SWP_REG_SECT) ? {16'(volatile_sector_bit_r), 16'(persistent_sector_bit_r)} :
		32'h0000_0000;

	// hardware reset pin synchroniser and filter
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			hw_s1_r <= 1'b1;
			hw_s2_r <= 1'b1;
			hw_s3_r <= 1'b1;
			hw_filt_r <= 1'b1;
		end else if (i_ce) begin
			hw_s1_r <= i_hw_reset_n;
			hw_s2_r <= hw_s1_r;
			hw_s3_r <= hw_s2_r;
			if (hw_s2_r == hw_s3_r) begin
				hw_filt_r <= hw_s2_r;
			end
		end
	end

	// bus handshake, one wait cycle per access
	// status always readable
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			wait_r <= 1'b1;
			rdata_r <= 32'h0000_0000;
		end else if (i_ce) begin
			wait_r <= ~(req & wait_r);
			if (req & wait_r) begin
				rdata_r <= i_avs_read ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// host holding registers
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			pw_lo_r <= 32'h0000_0000;
			pw_hi_r <= 32'h0000_0000;
			cfg_data_r <= SWP_CFG_RESET;
		end else if (i_ce & wr_take) begin
			if (i_avs_address == SWP_REG_PW_LO) begin
				pw_lo_r <= i_avs_writedata;
			end
			if (i_avs_address == SWP_REG_PW_HI) begin
				pw_hi_r <= i_avs_writedata;
			end
			if (i_avs_address == SWP_REG_CFG) begin
				cfg_data_r <= i_avs_writedata[15:0];
			end
		end
	end

	// embedded algorithm sequencing
	// lock 0 runs full time then aborts
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			state_r <= SWP_ST_IDLE;
			timer_r <= 16'h0000;
			op_r <= 4'h0;
			op_sect_r <= '0;
			op_abort_r <= 1'b0;
		end else if (i_ce) begin
			case (state_r)
				SWP_ST_IDLE: begin
					if (go_busy & ~hw_rst) begin
						state_r <= SWP_ST_BUSY;
						timer_r <= start_time;
						op_r <= cmd_op;
						op_sect_r <= cmd_sect;
						op_abort_r <= start_abort;
					end
				end
				SWP_ST_BUSY: begin
					timer_r <= timer_r - 16'h0001;
					if (done | hw_rst) begin
						state_r <= SWP_ST_IDLE;
					end
				end
				default: begin
					state_r <= SWP_ST_IDLE;
				end
			endcase
		end
	end

	// persistent bits, power-on only
	// single program, group erase
	// changed only while lock was 1
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			persistent_sector_bit_r <= '1;
		end else if (i_ce & done_ok & ~hw_rst) begin
			if (is_prog) begin
				persistent_sector_bit_r <= persistent_sector_bit_r & ~swp_onehot(op_sect_r);
			end else if (is_erase) begin
				persistent_sector_bit_r <= '1;
			end
		end
	end

	// guard config and hidden password, programs zeros only
	// mode fixed by otp bits
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			guard_config_word_r <= SWP_CFG_RESET;
			password_r <= 64'hFFFF_FFFF_FFFF_FFFF;
		end else if (i_ce & done_ok & ~hw_rst) begin
			if (is_cfg) begin
				guard_config_word_r <= guard_config_word_r & cfg_data_r;
			end
			if (is_pw) begin
				password_r <= password_r & {pw_hi_r, pw_lo_r};
			end
		end
	end

	// persistent bit lock
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			lock_r <= 1'b1;
		end else if (i_ce) begin
			if (hw_rst) begin
				lock_r <= ~mode_pw;
			end else if (go_lock_clr) begin
				lock_r <= 1'b0;
			end else if (go_unlock & mode_pw & pw_match) begin
				lock_r <= 1'b1;
			end
		end
	end

	// dynamic bits
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			volatile_sector_bit_r <= '1;
		end else if (i_ce) begin
			if (hw_rst) begin
				volatile_sector_bit_r <= '1;
			end else if (go_dyb_p) begin
				volatile_sector_bit_r <= volatile_sector_bit_r & ~swp_onehot(cmd_sect);
			end else if (go_dyb_u) begin
				volatile_sector_bit_r <= volatile_sector_bit_r | swp_onehot(cmd_sect);
			end
		end
	end

	// overlay space, status flags
	// software reset touches no lock
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			aso_r <= 1'b0;
			ppb_rd_r <= 1'b0;
			err_prog_r <= 1'b0;
			err_erase_r <= 1'b0;
			err_lock_r <= 1'b0;
		end else if (i_ce) begin
			if (hw_rst) begin
				aso_r <= 1'b0;
				ppb_rd_r <= 1'b0;
				err_prog_r <= 1'b0;
				err_erase_r <= 1'b0;
				err_lock_r <= 1'b0;
			end else begin
				if (go_aso_in) begin
					aso_r <= 1'b1;
				end else if (go_aso_out) begin
					aso_r <= 1'b0;
				end
				if (go_ppb_rd) begin
					ppb_rd_r <= persistent_sector_bit_r[cmd_sect];
				end
				err_prog_r <= err_prog_nxt;
				err_erase_r <= err_erase_nxt;
				err_lock_r <= err_lock_nxt;
			end
		end
	end

	// write gate toward the array
	// both bits must be 1
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n) begin
			ok_r <= '1;
		end else if (i_ce) begin
			ok_r <= persistent_sector_bit_r & volatile_sector_bit_r;
		end
	end

	// outputs
	assign o_avs_readdata = rdata_r;
	assign o_avs_waitrequest = wait_r;
	assign o_sector_write_ok = ok_r;
	assign o_persistent_bit_lock = lock_r;
endmodule

/* include/swp_pkg.sv */
// constants and types for the sector write protection block
package swp_pkg;
	// register word indexes
	localparam logic [3:0] SWP_REG_CMD = 4'h0;
	localparam logic [3:0] SWP_REG_STATUS = 4'h1;
	localparam logic [3:0] SWP_REG_PW_LO = 4'h2;
	localparam logic [3:0] SWP_REG_PW_HI = 4'h3;
	localparam logic [3:0] SWP_REG_CFG = 4'h4;
	localparam logic [3:0] SWP_REG_SECT = 4'h5;
	// command word fields
	localparam int SWP_CMD_OP_LSB = 0;
	localparam int SWP_CMD_SECT_LSB = 8;
	// command opcodes
	localparam logic [3:0] SWP_OP_PPB_PROG = 4'h1;
	localparam logic [3:0] SWP_OP_PPB_ERASE = 4'h2;
	localparam logic [3:0] SWP_OP_LOCK_CLEAR = 4'h3;
	localparam logic [3:0] SWP_OP_PW_UNLOCK = 4'h4;
	localparam logic [3:0] SWP_OP_DYB_PROTECT = 4'h5;
	localparam logic [3:0] SWP_OP_DYB_UNPROTECT = 4'h6;
	localparam logic [3:0] SWP_OP_ASO_ENTER = 4'h7;
	localparam logic [3:0] SWP_OP_ASO_EXIT = 4'h8;
	localparam logic [3:0] SWP_OP_PPB_STATUS = 4'h9;
	localparam logic [3:0] SWP_OP_CFG_PROG = 4'hA;
	localparam logic [3:0] SWP_OP_PW_PROG = 4'hB;
	localparam logic [3:0] SWP_OP_STATUS_CLEAR = 4'hC;
	localparam logic [3:0] SWP_OP_SW_RESET = 4'hD;
	// status word bit positions
	localparam int SWP_ST_PPB_RD = 0;
	localparam int SWP_ST_LOCK_ERR = 1;
	localparam int SWP_ST_PROG_ERR = 4;
	localparam int SWP_ST_ERASE_ERR = 5;
	localparam int SWP_ST_READY = 7;
	localparam int SWP_ST_LOCK = 8;
	localparam int SWP_ST_ASO = 9;
	// guard config word
	localparam logic [15:0] SWP_CFG_RESET = 16'hFEFF;
	localparam int SWP_CFG_MODE_LSB = 1;
	localparam logic [1:0] SWP_MODE_NONE = 2'h0;
	localparam logic [1:0] SWP_MODE_PASSWORD = 2'h1;
	localparam logic [1:0] SWP_MODE_BOOT_PERM = 2'h2;
	localparam logic [1:0] SWP_MODE_BOOT_TEMP = 2'h3;
	// timing
	localparam int SWP_CLK_PERIOD_NS = 25;
	localparam int SWP_PROG_TIME_NS = 2000;
	localparam int SWP_ERASE_TIME_NS = 8000;
	localparam int SWP_PROG_CYCLES = (SWP_PROG_TIME_NS + SWP_CLK_PERIOD_NS - 1) / SWP_CLK_PERIOD_NS;
	localparam int SWP_ERASE_CYCLES = (SWP_ERASE_TIME_NS + SWP_CLK_PERIOD_NS - 1) / SWP_CLK_PERIOD_NS;
	// embedded algorithm states
	typedef enum logic [1:0] {
		SWP_ST_IDLE = 2'b00,
		SWP_ST_BUSY = 2'b01
	} swp_state_type;
endpackage

/* verification/swp_host_model.sv */
// avalon-mm host model issuing command and register accesses
module swp_host_model (
	// clock
	input wire logic i_mclk,
	// slave answer
	input wire logic i_waitrequest,
	input wire logic [31:0] i_readdata,
	// request
	output logic [3:0] o_address = 4'h0,
	output logic o_read = 1'b0,
	output logic o_write = 1'b0,
	output logic [31:0] o_writedata = 32'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	// one access, held until waitrequest is seen low or 64 cycles pass
	task automatic xfer(input bit we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q, output bit ok);
		int n;
		n = 0;
		@(posedge i_mclk);
		o_read <= !we;
		o_write <= we;
		o_address <= a;
		o_writedata <= d;
		do begin
			@(posedge i_mclk);
			n++;
		end while (i_waitrequest !== 1'b0 && n < 64);
		q = i_readdata;
		ok = (n < 64);
		o_read <= 1'b0;
		o_write <= 1'b0;
		// released lines do not keep their last value
		o_address <= ~a;
		o_writedata <= ~d;
	endtask
endmodule

/* verification/swp_prop_properties.sv */
// port checker for the sector write protection block
module swp_prop_checker
	import swp_pkg::*;
#(
	parameter int SECTORS = 16
) (
	// clock and resets
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic i_hw_reset_n,
	// avalon-mm slave
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// protection state
	input wire logic [SECTORS-1:0] o_sector_write_ok,
	input wire logic o_persistent_bit_lock
);
	logic [7:0] quiet_r;
	logic [3:0] sect_r;
	wire cmd_take = i_avs_write && !o_avs_waitrequest && i_avs_address == SWP_REG_CMD;
	wire [3:0] op = i_avs_writedata[3:0];
	wire quiet = quiet_r > 8'h10;
	always_ff @(posedge i_mclk) begin
		if (!i_reset_n || !i_hw_reset_n)
			quiet_r <= 8'h00;
		else if (quiet_r != 8'hFF)
			quiet_r <= quiet_r + 8'h01;
	end
	always_ff @(posedge i_mclk) begin
		if (cmd_take)
			sect_r <= i_avs_writedata[11:8];
	end
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	sequence s_cmd(logic [3:0] code);
		cmd_take && op == code && quiet;
	endsequence
	a_wait_one_low: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_req_answered: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("request not answered after one wait");
	a_wait_needs_req: assert property (!o_avs_waitrequest |-> $past(i_avs_read || i_avs_write))
		else $error("waitrequest low without a request");
	a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest
		&& i_avs_address > SWP_REG_SECT |-> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_lock_clear_zero: assert property (s_cmd(SWP_OP_LOCK_CLEAR) |=> !o_persistent_bit_lock)
		else $error("lock clear left lock set");
	a_swreset_keeps_lock: assert property (s_cmd(SWP_OP_SW_RESET)
		|=> $stable(o_persistent_bit_lock)) else $error("software reset changed lock");
	a_lock_rise_cause: assert property ($rose(o_persistent_bit_lock) |-> !quiet
		|| $past(cmd_take && op == SWP_OP_PW_UNLOCK)) else $error("lock rose without cause");
	a_dyb_blocks_write: assert property (s_cmd(SWP_OP_DYB_PROTECT)
		|-> ##2 !o_sector_write_ok[sect_r]) else $error("protected sector still writable");
	a_reset_all_open: assert property ($rose(i_reset_n)
		|-> o_persistent_bit_lock && &o_sector_write_ok) else $error("reset state wrong");
endmodule

bind swp_sector_write_protection swp_prop_checker #(.SECTORS(SECTORS)) u_prop_checker (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_hw_reset_n(i_hw_reset_n),
	.i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_sector_write_ok(o_sector_write_ok),
	.o_persistent_bit_lock(o_persistent_bit_lock));

/* verification/swp_sector_write_protection_tb_top.sv */
// self-checking bench for the sector write protection block
module swp_sector_write_protection_tb_top;
	import swp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int k; logic [3:0] a; logic [31:0] d;} swp_row_type;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic hw_n = 1'b1;
	logic ce = 1'b1;
	logic [3:0] addr;
	logic rd, wr, waitreq, lock;
	logic [31:0] wdata, rdata;
	logic [15:0] wok;
	int bad_count = 0;
	int checked = 0;
	swp_row_type rows[$];
	initial begin
		forever #12.5 mclk = ~mclk;
	end
	swp_sector_write_protection #(.SECTORS(16), .PROG_CYCLES(4), .ERASE_CYCLES(8)) dut (
		.i_mclk(mclk), .i_reset_n(reset_n), .i_ce(ce), .i_hw_reset_n(hw_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.o_sector_write_ok(wok), .o_persistent_bit_lock(lock));
	swp_host_model host (.i_mclk(mclk), .i_waitrequest(waitreq), .i_readdata(rdata),
		.o_address(addr), .o_read(rd), .o_write(wr), .o_writedata(wdata));
	task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask
	task automatic chk_bit(input string n, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %b seen %b", n, e, g);
			bad_count++;
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// kinds: 0 write, 1 read and compare, 2 wait ready, 3 pin reset pulse
	task automatic do_row(input int k, input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bit ok;
		int n;
		ok = 1'b1;
		q = 32'h0;
		n = 0;
		if (k == 3) begin
			@(posedge mclk);
			hw_n <= 1'b0;
			repeat (8) @(posedge mclk);
			hw_n <= 1'b1;
			repeat (20) @(posedge mclk);
		end
		while (k == 2 && ok && !q[SWP_ST_READY] && n < 100) begin
			host.xfer(1'b0, SWP_REG_STATUS, 32'h0, q, ok);
			n++;
		end
		if (k < 2) host.xfer(k == 0, a, d, q, ok);
		if (k == 1) chk_word($sformatf("register %0d", a), d, q);
		if (!ok || n == 100) begin
			bad_count++;
			end_sim();
		end
	endtask
	initial begin
		rows = '{'{1,4'h1,32'h180}, '{1,4'h5,32'hFFFFFFFF}, '{1,4'h4,32'hFEFF},
			'{1,4'hF,32'h0}, '{0,4'h0,32'h305}, '{1,4'h5,32'hFFF7FFFF},
			'{0,4'h0,32'h306}, '{1,4'h5,32'hFFFFFFFF}, '{0,4'h0,32'h201},
			'{1,4'h1,32'h100}, '{2,4'h1,32'h0}, '{1,4'h5,32'hFFFFFFFB},
			'{0,4'h0,32'h7}, '{0,4'h0,32'h509}, '{1,4'h1,32'h381},
			'{0,4'h0,32'h209}, '{1,4'h1,32'h380}, '{0,4'h0,32'h8},
			'{0,4'h0,32'h2}, '{2,4'h1,32'h0}, '{1,4'h5,32'hFFFFFFFF},
			'{0,4'h0,32'h3}, '{1,4'h1,32'h80}, '{0,4'h0,32'h4},
			'{1,4'h1,32'h80}, '{0,4'h0,32'hD}, '{1,4'h1,32'h80},
			'{0,4'h0,32'h105}, '{1,4'h5,32'hFFFDFFFF}, '{0,4'h0,32'h106},
			'{0,4'h0,32'h301}, '{2,4'h1,32'h0}, '{1,4'h1,32'h92},
			'{1,4'h5,32'hFFFFFFFF}, '{0,4'h0,32'h2}, '{2,4'h1,32'h0},
			'{1,4'h1,32'hB2}, '{0,4'h0,32'hC}, '{1,4'h1,32'h80},
			'{3,4'h0,32'h0}, '{1,4'h1,32'h180}, '{0,4'h2,32'h12345678},
			'{0,4'h3,32'h9ABCDEF0}, '{0,4'h0,32'hB}, '{2,4'h1,32'h0},
			'{1,4'h1,32'h180}, '{0,4'h4,32'hFFFB}, '{0,4'h0,32'hA},
			'{2,4'h1,32'h0}, '{1,4'h4,32'hFEFB}, '{0,4'h0,32'hA},
			'{2,4'h1,32'h0}, '{1,4'h1,32'h192}, '{0,4'h0,32'hC},
			'{3,4'h0,32'h0}, '{1,4'h1,32'h80}, '{0,4'h2,32'h12345679},
			'{0,4'h0,32'h4}, '{1,4'h1,32'h80}, '{0,4'h2,32'h12345678},
			'{0,4'h0,32'h4}, '{1,4'h1,32'h180}};
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		foreach (rows[i]) do_row(rows[i].k, rows[i].a, rows[i].d);
		$display("command table test done");
		do_row(0, SWP_REG_CMD, 32'h3);
		do_row(0, SWP_REG_CMD, 32'h605);
		repeat (3) @(posedge mclk);
		chk_bit("write ok sector 6", 1'b0, wok[6]);
		chk_bit("lock", 1'b0, lock);
		$display("write permission test done");
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (12) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk_word("write ok", 32'h0000FFFF, {16'h0, wok});
		chk_bit("lock", 1'b1, lock);
		do_row(1, SWP_REG_CFG, 32'hFEFF);
		$display("mid-run reset test done");
		do_row(0, SWP_REG_CFG, 32'hFFF9);
		do_row(0, SWP_REG_CMD, 32'hA);
		do_row(2, SWP_REG_STATUS, 32'h0);
		do_row(1, SWP_REG_STATUS, 32'h192);
		do_row(1, SWP_REG_CFG, 32'hFEFF);
		$display("both mode bits test done");
		do_row(0, SWP_REG_CMD, 32'h3);
		ce <= 1'b0;
		hw_n <= 1'b0;
		repeat (8) @(posedge mclk);
		hw_n <= 1'b1;
		repeat (4) @(posedge mclk);
		ce <= 1'b1;
		repeat (20) @(posedge mclk);
		chk_bit("lock frozen", 1'b0, lock);
		$display("clock enable test done");
		end_sim();
	end
endmodule
